// *** twps_pkg.sv ***
// constants and types shared by both ends of the two-wire pot link
// Summary of operation
// - three wiper bytes at f8h, f9h, fah
// - only low seven written bits kept
// - first byte: code, strap bit, direction
// - ack on code and strap match, else go idle
// - write sends memory address, acked, loaded
// - data byte acked; single write ends with stop
// - stop starts timed write; bus ignored meanwhile
// - page write up to eight acked bytes
// - page address wraps in low three bits
// - page data committed only on stop
// - no ack while busy; polling allowed
// - pointer is last address plus one
// - read sends byte at pointer; nack, stop
// - random read: dummy write, restart, read
// - master ack fetches next byte, wraps
// - master ends read with nack, stop
// - protect pin low needed to change wipers
package twps_pkg;
	// wiper byte addresses
	localparam logic [7:0] POT1_ADDR = 8'hf8;
	localparam logic [7:0] POT0_ADDR = 8'hf9;
	localparam logic [7:0] POT2_ADDR = 8'hfa;
	localparam logic [7:0] POS_MASK  = 8'h7f;
	// wiper value before any write lands (maximum resistance)
	localparam logic [6:0] POS_RESET = 7'h7f;
	// device code; value is arbitrary
	localparam logic [5:0] DEV_CODE_DFLT = 6'h2d;
	localparam int PAGE_BITS = 3;
	localparam logic [3:0] ACK_BIT = 4'h8;
	// system clock and timed-write figures
	localparam int CLK_PERIOD_NS = 5;
	localparam int WR_TIME_NS    = 10000;
	localparam int WR_CYCLES = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// quarter of a master bit period
	localparam int SCL_QTR_NS  = 625;
	localparam int SCL_QTR_CYC = SCL_QTR_NS / CLK_PERIOD_NS;
	// device protocol states
	typedef enum logic [2:0] {
		DS_IDLE, DS_DEV, DS_ADDR, DS_WDATA, DS_ACK, DS_RDATA, DS_MACK, DS_BUSY
	} twps_dev_state_t;
	// master sequencer states and byte roles
	typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} twps_host_state_t;
	typedef enum logic [1:0] {SG_DEV, SG_ADDR, SG_WR, SG_RD} twps_seg_t;
endpackage

// *** twps_if.sv ***
// open-drain two-wire bus joining master and device ends
`timescale 1ns/1ps
interface twps_if;
	logic scl_o;     // master clock value (held low)
	logic scl_oe;    // master pulls clock low
	logic m_sda_o;   // master data value (held low)
	logic m_sda_oe;  // master pulls data low
	logic d_sda_o;   // device data value (held low)
	logic d_sda_oe;  // device pulls data low
	logic scl;       // resolved clock wire
	logic sda;       // resolved data wire
	// wired-and with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
	modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe, input scl, sda);
	modport device (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// *** twps_sync.sv ***
// two-flop synchroniser with a third stage for edge finding
`timescale 1ns/1ps
module twps_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// asynchronous levels
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised level and its previous value
	output logic      [WIDTH-1:0] sync_q,
	output logic      [WIDTH-1:0] sync_prev
);
	logic [WIDTH-1:0] meta;  // read only by sync_q

	if (WIDTH < 1) begin : g_bad_width
		$error("twps_sync: WIDTH must be at least 1");
	end

	// clock and data idle high, so reset high avoids false edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta      <= '1;
			sync_q    <= '1;
			sync_prev <= '1;
		end else begin
			meta      <= async_in;
			sync_q    <= meta;
			sync_prev <= sync_q;
		end
	end
endmodule

// *** twps_device.sv ***
// device end: two-wire slave holding three wiper positions
`timescale 1ns/1ps
module twps_device #(
	parameter logic [5:0] DEV_CODE  = twps_pkg::DEV_CODE_DFLT,
	parameter int         WR_CYCLES = twps_pkg::WR_CYCLES
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// bus side
	twps_if.device          bus,
	// straps
	input  wire logic       address_select_pin,
	input  wire logic       write_protect,
	// wiper positions and write status
	output logic      [6:0] pot0_position,
	output logic      [6:0] pot1_position,
	output logic      [6:0] pot2_position,
	output logic            nv_busy
);
	localparam int TW = $clog2(WR_CYCLES + 1);

	if (WR_CYCLES < 1) begin : g_bad_wr
		$error("twps_device: WR_CYCLES must be at least 1");
	end

	twps_pkg::twps_dev_state_t state;     // protocol state
	twps_pkg::twps_dev_state_t ack_next;  // state after the ack slot
	logic [3:0]    bit_cnt;    // bits clocked in this byte
	logic [7:0]    shreg;      // shift register
	logic [7:0]    ptr;        // address pointer
	logic          mack_ok;    // master acked last read byte
	logic          sda_drive;  // pull data low
	logic [7:0]    pbuf [8];   // page staging bytes
	logic [7:0]    pvalid;     // staged byte flags
	logic [4:0]    page;       // page under write
	logic          wr_pend;    // staged data awaits stop
	logic [TW-1:0] tmr;        // timed-write counter
	logic [6:0]    wiper [3];  // slot 0 = pot1, 1 = pot0, 2 = pot2
	logic [3:0]    pins_q;     // synchronised scl, sda, strap, protect
	logic [3:0]    pins_p;     // one cycle older

	// every pin crosses two flops before use
	twps_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.async_in  ({bus.scl, bus.sda, address_select_pin, write_protect}),
		.sync_q    (pins_q),
		.sync_prev (pins_p)
	);

	logic scl_s;
	logic sda_s;
	logic a0_s;
	logic wp_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic byte_in;
	logic commit;
	logic tmr_done;
	logic [7:0] rd_now;  // byte at the pointer, ready to send

	assign scl_s      = pins_q[3];
	assign sda_s      = pins_q[2];
	assign a0_s       = pins_q[1];
	assign wp_s       = pins_q[0];
	assign scl_rise   = scl_s && !pins_p[3];
	assign scl_fall   = !scl_s && pins_p[3];
	// data edges while clock stays high mark start and stop
	assign start_seen = scl_s && pins_p[3] && pins_p[2] && !sda_s;
	assign stop_seen  = scl_s && pins_p[3] && !pins_p[2] && sda_s;
	assign byte_in    = scl_fall && (bit_cnt == twps_pkg::ACK_BIT);
	assign tmr_done   = (tmr == '0);
	// stop after staged data launches the timed write
	assign commit     = stop_seen && wr_pend && (state != twps_pkg::DS_BUSY);

	// read value at an address; unmapped bytes read zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == twps_pkg::POT1_ADDR) begin
			r = {1'b0, wiper[0]};
		end else if (a == twps_pkg::POT0_ADDR) begin
			r = {1'b0, wiper[1]};
		end else if (a == twps_pkg::POT2_ADDR) begin
			r = {1'b0, wiper[2]};
		end
		return r;
	endfunction

	// byte at the pointer; always_comb also follows the wiper flops read inside
	always_comb begin
		rd_now = rd_byte(ptr);
	end

	// protocol sequencer: bits in on rising clock, drive after falling
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= twps_pkg::DS_IDLE;
			ack_next  <= twps_pkg::DS_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			ptr       <= 8'h00;
			mack_ok   <= 1'b0;
			sda_drive <= 1'b0;
		end else if (state == twps_pkg::DS_BUSY) begin
			// inputs disabled; nothing is acked until the timer ends
			sda_drive <= 1'b0;
			if (tmr_done) begin
				state <= twps_pkg::DS_IDLE;
			end
		end else if (commit) begin
			sda_drive <= 1'b0;
			state     <= twps_pkg::DS_BUSY;
		end else if (stop_seen) begin
			// plain stop drops back to idle
			sda_drive <= 1'b0;
			state     <= twps_pkg::DS_IDLE;
		end else if (start_seen) begin
			// start or repeated start opens a new address byte
			sda_drive <= 1'b0;
			bit_cnt   <= 4'h0;
			state     <= twps_pkg::DS_DEV;
		end else if (scl_rise) begin
			case (state)
				twps_pkg::DS_DEV, twps_pkg::DS_ADDR, twps_pkg::DS_WDATA: begin
					// sample a received bit, msb first
					shreg   <= {shreg[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end
				twps_pkg::DS_RDATA: begin
					shreg   <= {shreg[6:0], 1'b0};
					bit_cnt <= bit_cnt + 4'h1;
				end
				twps_pkg::DS_MACK: begin
					mack_ok <= !sda_s;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				twps_pkg::DS_DEV: begin
					if (byte_in) begin
						if (shreg[7:2] == DEV_CODE && shreg[1] == a0_s) begin
							sda_drive <= 1'b1;
							state     <= twps_pkg::DS_ACK;
							ack_next  <= shreg[0] ? twps_pkg::DS_RDATA
							                      : twps_pkg::DS_ADDR;
						end else begin
							// mismatch: stay off the bus until next start
							state <= twps_pkg::DS_IDLE;
						end
					end
				end
				twps_pkg::DS_ADDR: begin
					if (byte_in) begin
						ptr       <= shreg;
						sda_drive <= 1'b1;
						state     <= twps_pkg::DS_ACK;
						ack_next  <= twps_pkg::DS_WDATA;
					end
				end
				twps_pkg::DS_WDATA: begin
					if (byte_in) begin
						// advance within the page only
						ptr       <= {ptr[7:3], ptr[2:0] + 3'h1};
						sda_drive <= 1'b1;
						state     <= twps_pkg::DS_ACK;
						ack_next  <= twps_pkg::DS_WDATA;
					end
				end
				twps_pkg::DS_ACK: begin
					// ack slot over: release, then send or receive
					bit_cnt <= 4'h0;
					state   <= ack_next;
					if (ack_next == twps_pkg::DS_RDATA) begin
						shreg     <= rd_now;
						sda_drive <= !rd_now[7];
						ptr       <= ptr + 8'h01;
					end else begin
						sda_drive <= 1'b0;
					end
				end
				twps_pkg::DS_RDATA: begin
					if (byte_in) begin
						// leave the line free for the master's answer
						sda_drive <= 1'b0;
						state     <= twps_pkg::DS_MACK;
					end else begin
						sda_drive <= !shreg[7];
					end
				end
				twps_pkg::DS_MACK: begin
					if (mack_ok) begin
						// master wants more: next byte, pointer wraps ffh to 00h
						bit_cnt   <= 4'h0;
						shreg     <= rd_now;
						sda_drive <= !rd_now[7];
						ptr       <= ptr + 8'h01;
						state     <= twps_pkg::DS_RDATA;
					end else begin
						// nack: keep data high and wait for stop
						sda_drive <= 1'b0;
						state     <= twps_pkg::DS_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// page staging: bytes collect here and wait for the stop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pvalid  <= 8'h00;
			page    <= 5'h00;
			wr_pend <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				pbuf[i] <= 8'h00;
			end
		end else if (state == twps_pkg::DS_BUSY || commit) begin
			wr_pend <= 1'b0;
			pvalid  <= 8'h00;
		end else if (start_seen) begin
			// a restart without stop throws staged data away
			wr_pend <= 1'b0;
			pvalid  <= 8'h00;
		end else if (state == twps_pkg::DS_ADDR && byte_in) begin
			page <= shreg[7:twps_pkg::PAGE_BITS];
		end else if (state == twps_pkg::DS_WDATA && byte_in) begin
			// later byte at the same slot overwrites after a wrap
			pbuf[ptr[2:0]]   <= shreg;
			pvalid[ptr[2:0]] <= 1'b1;
			wr_pend          <= 1'b1;
		end
	end

	// wiper store: updated only by a committed, unprotected write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				wiper[i] <= twps_pkg::POS_RESET;
			end
		end else if (commit && !wp_s) begin
			for (int i = 0; i < 3; i++) begin
				// slot i lives at byte f8h + i, inside page 1fh
				if (page == twps_pkg::POT1_ADDR[7:3] && pvalid[i]) begin
					wiper[i] <= pbuf[i][6:0];
				end
			end
		end
	end

	// timed write length; the bus is deaf until it expires
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= '0;
		end else if (commit) begin
			tmr <= TW'(WR_CYCLES - 1);
		end else if (!tmr_done) begin
			tmr <= tmr - TW'(1);
		end
	end

	// registered status for the user side
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nv_busy <= 1'b0;
		end else begin
			nv_busy <= (state == twps_pkg::DS_BUSY) || commit;
		end
	end

	// wiper outputs straight from the store flops
	assign pot1_position = wiper[0];
	assign pot0_position = wiper[1];
	assign pot2_position = wiper[2];
	// open drain: value low, enable carries the drive
	assign bus.d_sda_o   = 1'b0;
	assign bus.d_sda_oe  = sda_drive;
endmodule

// *** twps_host.sv ***
// master end: drives clock, start, stop and byte transfers
`timescale 1ns/1ps
module twps_host #(
	parameter logic [5:0] DEV_CODE = twps_pkg::DEV_CODE_DFLT,
	parameter int         QTR_CYC  = twps_pkg::SCL_QTR_CYC
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// bus side
	twps_if.master          bus,
	// request port
	input  wire logic       req,
	input  wire logic       req_read,
	input  wire logic       req_random,
	input  wire logic       req_sel,
	input  wire logic [7:0] req_addr,
	input  wire logic [3:0] req_len,
	// write data stream
	input  wire logic [7:0] wr_data,
	output logic            wr_take,
	// read data stream and status
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	output logic            busy,
	output logic            done,
	output logic            nack
);
	localparam int QW = $clog2(QTR_CYC + 1);

	if (QTR_CYC < 4) begin : g_bad_qtr
		$error("twps_host: QTR_CYC must be at least 4");
	end

	twps_pkg::twps_host_state_t state;  // sequencer state
	twps_pkg::twps_seg_t        seg;    // role of current byte
	logic [QW-1:0] qcnt;      // quarter timer
	logic [1:0]    phase;     // quarter within bit
	logic [3:0]    bitn;      // bit within byte, 8 = ack
	logic [7:0]    sh;        // shift register
	logic [3:0]    left;      // data bytes still to move
	logic          rd_mode;   // request is a read
	logic          rnd_mode;  // dummy write still pending
	logic          sel;       // strap bit to address
	logic [7:0]    addr;      // memory address
	logic          got_ack;   // device answered low
	logic          scl_drv;   // pull clock low
	logic          sda_drv;   // pull data low
	logic          sda_q;     // synchronised data
	logic          tick;

	// data wire crosses two flops; prev copy unused here
	twps_sync #(
		.WIDTH(1)
	) u_sync (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.async_in  (bus.sda),
		.sync_q    (sda_q),
		.sync_prev ()
	);

	assign tick = (qcnt == '0);

	// quarter-period divider that paces the clock line
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			qcnt <= '0;
		end else if (state == twps_pkg::HS_IDLE || tick) begin
			qcnt <= QW'(QTR_CYC - 1);
		end else begin
			qcnt <= qcnt - QW'(1);
		end
	end

	// sequencer: one bit per four quarters
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= twps_pkg::HS_IDLE;
			seg      <= twps_pkg::SG_DEV;
			phase    <= 2'h0;
			bitn     <= 4'h0;
			sh       <= 8'h00;
			left     <= 4'h0;
			rd_mode  <= 1'b0;
			rnd_mode <= 1'b0;
			sel      <= 1'b0;
			addr     <= 8'h00;
			got_ack  <= 1'b0;
			scl_drv  <= 1'b0;
			sda_drv  <= 1'b0;
			wr_take  <= 1'b0;
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
			busy     <= 1'b0;
			done     <= 1'b0;
			nack     <= 1'b0;
		end else begin
			wr_take  <= 1'b0;
			rd_valid <= 1'b0;
			done     <= 1'b0;
			if (state == twps_pkg::HS_IDLE) begin
				if (req) begin
					// latch the whole request
					rd_mode  <= req_read;
					rnd_mode <= req_read && req_random;
					sel      <= req_sel;
					addr     <= req_addr;
					left     <= req_len;
					nack     <= 1'b0;
					busy     <= 1'b1;
					phase    <= 2'h0;
					state    <= twps_pkg::HS_START;
				end
			end else if (tick) begin
				phase <= phase + 2'h1;
				case (state)
					twps_pkg::HS_START: begin
						// data falls while clock is high
						case (phase)
							2'h0: sda_drv <= 1'b0;
							2'h1: scl_drv <= 1'b0;
							2'h2: sda_drv <= 1'b1;
							default: begin
								scl_drv <= 1'b1;
								bitn    <= 4'h0;
								seg     <= twps_pkg::SG_DEV;
								sh      <= {DEV_CODE, sel, rd_mode && !rnd_mode};
								state   <= twps_pkg::HS_BIT;
							end
						endcase
					end
					twps_pkg::HS_BIT: begin
						case (phase)
							2'h0: begin
								// set data while clock is low
								if (bitn != twps_pkg::ACK_BIT) begin
									sda_drv <= (seg != twps_pkg::SG_RD) && !sh[7];
								end else begin
									sda_drv <= (seg == twps_pkg::SG_RD) && (left != 4'h1);
								end
							end
							2'h1: scl_drv <= 1'b0;
							2'h2: begin
								// sample mid-high: shift serves both directions
								if (bitn != twps_pkg::ACK_BIT) begin
									sh <= {sh[6:0], sda_q};
								end else begin
									got_ack <= !sda_q;
								end
							end
							default: begin
								scl_drv <= 1'b1;
								if (bitn != twps_pkg::ACK_BIT) begin
									bitn <= bitn + 4'h1;
								end else begin
									bitn <= 4'h0;
									case (seg)
										twps_pkg::SG_DEV: begin
											if (!got_ack) begin
												// busy or absent device: stop, retry later
												nack  <= 1'b1;
												state <= twps_pkg::HS_STOP;
											end else if (rd_mode && !rnd_mode) begin
												seg <= twps_pkg::SG_RD;
											end else begin
												seg <= twps_pkg::SG_ADDR;
												sh  <= addr;
											end
										end
										twps_pkg::SG_ADDR: begin
											if (rnd_mode) begin
												// repeated start, then read direction
												rnd_mode <= 1'b0;
												state    <= twps_pkg::HS_START;
											end else if (left == 4'h0) begin
												state <= twps_pkg::HS_STOP;
											end else begin
												seg     <= twps_pkg::SG_WR;
												sh      <= wr_data;
												wr_take <= 1'b1;
											end
										end
										twps_pkg::SG_WR: begin
											if (!got_ack || left == 4'h1) begin
												nack  <= !got_ack;
												state <= twps_pkg::HS_STOP;
											end else begin
												left    <= left - 4'h1;
												sh      <= wr_data;
												wr_take <= 1'b1;
											end
										end
										default: begin
											rd_data  <= sh;
											rd_valid <= 1'b1;
											if (left == 4'h1) begin
												state <= twps_pkg::HS_STOP;
											end else begin
												left <= left - 4'h1;
											end
										end
									endcase
								end
							end
						endcase
					end
					default: begin
						// stop: data rises while clock is high
						case (phase)
							2'h0: sda_drv <= 1'b1;
							2'h1: scl_drv <= 1'b0;
							2'h2: sda_drv <= 1'b0;
							default: begin
								done  <= 1'b1;
								busy  <= 1'b0;
								state <= twps_pkg::HS_IDLE;
							end
						endcase
					end
				endcase
			end
		end
	end

	// open drain: values low, enables carry the drive
	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = scl_drv;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = sda_drv;
endmodule

// *** twps_sva.sv ***
// link checker for the two-wire pot bus
`timescale 1ns/1ps
module twps_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// link signals
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// data edges under a high clock
	sequence start_seen;
		scl && $fell(sda);
	endsequence
	sequence stop_seen;
		scl && $rose(sda);
	endsequence
	// clock stays high a while after a start
	a_start_hold: assert property (start_seen |-> scl [*4])
		else $error("clock fell too soon after start");
	// data line stays high for eight cycles after a stop
	a_stop_idle: assert property (stop_seen |-> sda [*8])
		else $error("data line fell right after stop");
	// clock high and low phases last at least eight cycles
	a_clock_high: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	a_clock_low: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");
	// device only starts driving shortly after a clock fall
	a_drive_after_fall: assert property ($rose(d_sda_oe) |->
		!scl && !$past(scl, 2) && $past(scl, 6))
		else $error("device drove data outside a low clock");
	// an acknowledge or data bit is held at least eight cycles once driven
	a_drive_hold: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
		else $error("device released its bit too early");
	// device never changes data while clock is high
	a_dev_stable_high: assert property (scl && $past(scl) && $past(scl, 4)
		|-> $stable(d_sda_oe))
		else $error("device changed data while clock high");
	// master lets go while the device answers
	a_master_released: assert property (d_sda_oe && scl |-> !m_sda_oe)
		else $error("master drove data during device bit");
	// open-drain value pins only ever hold a low
	a_drive_low_only: assert property (!scl_o && !m_sda_o && !d_sda_o)
		else $error("open-drain value pin driven high");
endmodule

// *** two_wire_pot_register_slave_test.sv ***
// self-checking bench: host and device ends joined on one link
`timescale 1ns/1ps
module two_wire_pot_register_slave_test;
	localparam int QTR = 8;    // short bit time for simulation
	localparam int WRC = 600;  // shortened timed write, longer than one poll
	logic       sys_clk;       // system clock
	logic       rst_n;         // reset, active low
	logic       req, req_read, req_random, req_sel, sel_pin, wp;
	logic [7:0] req_addr, wr_data, rd_data;
	logic [3:0] req_len;
	logic       wr_take, rd_valid, done, nack, nv_busy, busy;
	logic [6:0] pot0_position, pot1_position, pot2_position;
	logic [7:0] slot [3];      // model wipers f8, f9, fa
	logic [7:0] wbuf [16];     // bytes queued for the host
	logic [7:0] rq [$];        // bytes read back
	int         ptr, wi;       // model pointer, write index
	int         fails, comparisons;
	twps_if bus_if ();
	twps_host #(.QTR_CYC(QTR)) twps_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus_if), .req(req), .req_read(req_read), .req_random(req_random),
		.req_sel(req_sel), .req_addr(req_addr), .req_len(req_len), .wr_data(wr_data),
		.wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
		.done(done), .nack(nack));
	twps_device #(.WR_CYCLES(WRC)) twps_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus_if), .address_select_pin(sel_pin), .write_protect(wp),
		.pot0_position(pot0_position), .pot1_position(pot1_position),
		.pot2_position(pot2_position), .nv_busy(nv_busy));
	twps_sva twps_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n), .scl_o(bus_if.scl_o),
		.scl_oe(bus_if.scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
		.d_sda_o(bus_if.d_sda_o), .d_sda_oe(bus_if.d_sda_oe), .scl(bus_if.scl),
		.sda(bus_if.sda));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// feed write bytes and collect read bytes
	always @(posedge sys_clk) begin
		if (wr_take) begin
			wi <= wi + 1;
			wr_data <= wbuf[wi + 1];
		end
		if (rd_valid) begin
			rq.push_back(rd_data);
		end
	end
	// model read: unmapped places read zero
	function automatic logic [7:0] mrd(input int a);
		return (a >= 248 && a <= 250) ? slot[a - 248] : 8'h00;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one host request, waits for done under a bound
	task automatic xfer(input logic rd, rnd, s, input logic [7:0] a, input int n);
		int k;
		@(posedge sys_clk);
		req <= 1'b1;
		req_read <= rd;
		req_random <= rnd;
		req_sel <= s;
		req_addr <= a;
		req_len <= 4'(n);
		wi <= 0;
		wr_data <= wbuf[0];
		@(posedge sys_clk);
		req <= 1'b0;
		@(negedge sys_clk);
		check(8'(busy), 8'h01);
		k = 0;
		while (done !== 1'b1 && k < 20000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 20000) begin
			fails++;
			give_verdict();
		end else begin
			check(8'(busy), 8'h00);
		end
	endtask
	// page write with random bytes; model wraps in the page
	task automatic wr(input logic [7:0] a, input int n);
		logic [7:0] s;
		for (int i = 0; i < n; i++) begin
			wbuf[i] = 8'($urandom);
			s = {a[7:3], a[2:0] + 3'(i)};
			if (!wp && s >= 8'hf8 && s <= 8'hfa) slot[s - 8'hf8] = wbuf[i] & twps_pkg::POS_MASK;
		end
		ptr = {a[7:3], a[2:0] + 3'(n)};
		xfer(1'b0, 1'b0, sel_pin, a, n);
		check(8'(nack), 8'h00);
	endtask
	// wait out the timed write, then compare wipers
	task automatic settle;
		int k;
		k = 0;
		repeat (8) @(negedge sys_clk);
		while (nv_busy !== 1'b0 && k < 5000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 5000) begin
			fails++;
			give_verdict();
		end else begin
			check(8'(pot1_position), slot[0]);
			check(8'(pot0_position), slot[1]);
			check(8'(pot2_position), slot[2]);
		end
	endtask
	// random or current read of n bytes
	task automatic rdq(input logic rnd, input logic [7:0] a, input int n);
		if (rnd) ptr = a;
		rq.delete();
		xfer(1'b1, rnd, sel_pin, a, n);
		check(8'(rq.size()), 8'(n));
		for (int i = 0; i < n; i++) begin
			check(rq[i], mrd(ptr));
			ptr = (ptr + 1) % 256;
		end
	endtask
	// main sequence
	initial begin
		{req, req_read, req_random, req_sel, sel_pin, wp, rst_n} = '0;
		req_addr = 8'h00;
		req_len = 4'h0;
		wr_data = 8'h00;
		wi = 0;
		slot = '{8'h7f, 8'h7f, 8'h7f};
		ptr = 0;
		void'($urandom(32'h64b1));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		sel_pin <= 1'($urandom);
		repeat (4) @(posedge sys_clk);
		wr(8'hf8, 3);
		xfer(1'b1, 1'b0, sel_pin, 8'h00, 1); // polled during timed write
		check(8'(nack), 8'h01);
		settle();
		rdq(1'b1, 8'hf8, 3);
		rdq(1'b0, 8'h00, 1);
		wr(8'hfe, 4);
		settle();
		rdq(1'b0, 8'h00, 1);
		rdq(1'b1, 8'hff, 2);
		@(posedge sys_clk);
		wp <= 1'b1;
		@(posedge sys_clk);
		wr(8'hf9, 1);
		settle();
		@(posedge sys_clk);
		wp <= 1'b0;
		xfer(1'b0, 1'b0, ~sel_pin, 8'hf9, 1); // wrong strap bit
		check(8'(nack), 8'h01);
		repeat (8) @(negedge sys_clk);
		check(8'(nv_busy), 8'h00);
		rdq(1'b0, 8'h00, 1);
		give_verdict();
	end
	// watchdog against a hang
	initial begin
		#400000;
		fails++;
		give_verdict();
	end
endmodule
